// File: rtl/pmt8_pkg.sv
// Package for the 8-bit period match timer: register map, fields, resets.
// Assumes a 32-bit APB slave with each register on an aligned word.
package pmt8_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] PMT8_OFS_COUNTER = 8'h00;
    localparam logic [7:0] PMT8_OFS_LIMIT   = 8'h04;
    localparam logic [7:0] PMT8_OFS_CONTROL = 8'h08;
    localparam logic [7:0] PMT8_OFS_STATUS  = 8'h0c;
    localparam logic [7:0] PMT8_OFS_MASK    = 8'h10;

    // ==========================================================
    // Control field positions
    localparam int PMT8_CKPS_LSB  = 0;
    localparam int PMT8_RUN_BIT   = 2;
    localparam int PMT8_OUTPS_LSB = 3;
    localparam int PMT8_OUTPS_MSB = 6;

    // ==========================================================
    // Reset values
    localparam logic [7:0] PMT8_COUNTER_RST = 8'h00;
    localparam logic [7:0] PMT8_LIMIT_RST   = 8'hff;
    localparam logic [6:0] PMT8_CONTROL_RST = 7'h00;

    // ==========================================================
    // Instruction clock is the system clock divided by this plus one
    localparam logic [1:0] PMT8_ICLK_DIV_M1 = 2'h3;
    // Prescale terminal counts (ratio minus one)
    localparam logic [3:0] PMT8_PRE_1_M1  = 4'h0;
    localparam logic [3:0] PMT8_PRE_4_M1  = 4'h3;
    localparam logic [3:0] PMT8_PRE_16_M1 = 4'hf;

endpackage

// File: rtl/pmt8_divider.sv
// Clearable event divider: emits one pulse every (ratio_m1 + 1) input pulses.
// Assumes tick is a one-cycle pulse in the clk domain.
`timescale 1ns/1ps
module pmt8_divider (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Control
    input  wire logic       clr,
    input  wire logic [3:0] ratio_m1,
    // Events
    input  wire logic       tick,
    output logic            pulse
);
    logic [3:0] cnt_q;

    // Clear wins over a tick in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
        end else if (clr) begin
            cnt_q <= 4'h0;
        end else if (tick) begin
            cnt_q <= (cnt_q >= ratio_m1) ? 4'h0 : cnt_q + 4'h1;
        end
    end

    assign pulse = tick && !clr && (cnt_q >= ratio_m1);
endmodule // pmt8_divider

// File: rtl/pmt8_timer.sv
// Top of the 8-bit period match timer with APB register access.
// Assumes a single 125 MHz clock and inputs synchronous to it.
`timescale 1ns/1ps
// Contract
// - Count clock is only the instruction clock, system clock divided by four.
// - Prescaler divides by 1, 4 or 16; each output increments counter.
// - Period counter and period limit are eight-bit registers.
// - Counter and limit are compared continuously; equality raises match.
// - Counter counts up from zero, returns to zero on increment after match.
// - Each match advances postscaler dividing by one to sixteen.
// - Each postscaler output sets the match flag.
// - Software reads and writes counter and limit at any time.
// - Reset loads counter with zero and limit with all ones.
// - Run bit one starts the timer, zero stops it.
// - Control register fields select prescale and postscale ratios.
// - Writing the counter clears prescaler and postscaler counts.
// - Writing control clears prescaler and postscaler, keeps counter.
// - Every reset clears prescaler and postscaler counts.
// - Control writes never alter the period counter.
// - Output divider field bits six to three give ratio of value plus one.
module pmt8_timer
    import pmt8_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt
    output logic             irq
);
    // ==========================================================
    // State
    logic [7:0]  counter_q;
    logic [7:0]  limit_q;
    logic [6:0]  control_q;
    logic        flag_q;
    logic        mask_q;
    logic [1:0]  iclk_q;
    logic        irq_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    // ==========================================================
    // Bus decode
    logic        access;
    logic        wr_en;
    logic        wr_counter;
    logic        wr_limit;
    logic        wr_control;
    logic        wr_status;
    logic        wr_mask;
    logic        mapped;

    // Act in the first access cycle, answer in the next; pready registered, so one wait
    assign access = psel && penable && !pready_q;
    assign wr_en  = access && pwrite && pstrb[0];
    assign mapped = (paddr == PMT8_OFS_COUNTER) || (paddr == PMT8_OFS_LIMIT) ||
                    (paddr == PMT8_OFS_CONTROL) || (paddr == PMT8_OFS_STATUS) ||
                    (paddr == PMT8_OFS_MASK);
    assign wr_counter = wr_en && (paddr == PMT8_OFS_COUNTER);
    assign wr_limit   = wr_en && (paddr == PMT8_OFS_LIMIT);
    assign wr_control = wr_en && (paddr == PMT8_OFS_CONTROL);
    assign wr_status  = wr_en && (paddr == PMT8_OFS_STATUS);
    assign wr_mask    = wr_en && (paddr == PMT8_OFS_MASK);

    // ==========================================================
    // Control fields
    logic       run;
    logic [1:0] ckps;
    logic [3:0] outps;
    logic [3:0] pre_m1;

    assign run   = control_q[PMT8_RUN_BIT];
    assign ckps  = control_q[PMT8_CKPS_LSB +: 2];
    assign outps = control_q[PMT8_OUTPS_MSB:PMT8_OUTPS_LSB];

    always_comb begin
        case (ckps)
            2'b00:   pre_m1 = PMT8_PRE_1_M1;
            2'b01:   pre_m1 = PMT8_PRE_4_M1;
            default: pre_m1 = PMT8_PRE_16_M1;
        endcase
    end

    // ==========================================================
    // Instruction clock tick
    logic iclk_tick;
    // Free running so stopping the timer cannot shift its phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            iclk_q <= 2'h0;
        end else begin
            iclk_q <= iclk_q + 2'h1;
        end
    end
    assign iclk_tick = (iclk_q == PMT8_ICLK_DIV_M1) && run;

    // ==========================================================
    // Prescaler and postscaler
    logic scaler_clr;
    logic pre_pulse;
    logic match;
    logic match_tick;
    logic post_pulse;

    // Reset clears them through rst_n as well
    assign scaler_clr = wr_counter || wr_control;

    pmt8_divider u_prescaler (
        .clk      (clk),
        .rst_n    (rst_n),
        .clr      (scaler_clr),
        .ratio_m1 (pre_m1),
        .tick     (iclk_tick),
        .pulse    (pre_pulse)
    );

    assign match      = (counter_q == limit_q);
    assign match_tick = pre_pulse && match;

    pmt8_divider u_postscaler (
        .clk      (clk),
        .rst_n    (rst_n),
        .clr      (scaler_clr),
        .ratio_m1 (outps),
        .tick     (match_tick),
        .pulse    (post_pulse)
    );

    // ==========================================================
    // Period counter and limit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_q <= PMT8_COUNTER_RST;
        end else if (wr_counter) begin
            counter_q <= pwdata[7:0];
        end else if (pre_pulse) begin
            counter_q <= match ? PMT8_COUNTER_RST : counter_q + 8'h01;
        end
    end // control writes do not reach this register

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            limit_q <= PMT8_LIMIT_RST;
        end else if (wr_limit) begin
            limit_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_q <= PMT8_CONTROL_RST;
        end else if (wr_control) begin
            control_q <= pwdata[6:0];
        end
    end

    // ==========================================================
    // Match flag, mask and interrupt
    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (post_pulse) begin
            flag_q <= 1'b1;
        end else if (wr_status && pwdata[0]) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= 1'b0;
        end else if (wr_mask) begin
            mask_q <= pwdata[0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= flag_q && mask_q;
        end
    end

    // ==========================================================
    // APB answer
    logic [31:0] rd_mux;

    always_comb begin
        case (paddr)
            PMT8_OFS_COUNTER: rd_mux = {24'h000000, counter_q};
            PMT8_OFS_LIMIT:   rd_mux = {24'h000000, limit_q};
            PMT8_OFS_CONTROL: rd_mux = {25'h0000000, control_q};
            PMT8_OFS_STATUS:  rd_mux = {31'h00000000, flag_q};
            PMT8_OFS_MASK:    rd_mux = {31'h00000000, mask_q};
            default:          rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= access;
            pslverr_q <= access && !mapped;
            prdata_q  <= (access && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;
endmodule // pmt8_timer

// File: tb/pmt8_chk.sv
// Checker: APB answer timing and interrupt relations of pmt8_timer.
// Sees only the top ports; bound in below.
`timescale 1ns/1ps
module pmt8_chk
    import pmt8_pkg::*;
(
    // Clock, reset and APB
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Interrupt
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire acc = psel & penable & ~pready;
    wire rd  = pready & ~pwrite;
    property p_ans; acc |=> pready; endproperty
    property p_one; pready |=> !pready; endproperty
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    property p_idle; !pready |-> prdata == 32'h0; endproperty
    property p_cnt; rd && paddr == PMT8_OFS_COUNTER |-> prdata[31:8] == 24'h0; endproperty
    property p_ctl; rd && paddr == PMT8_OFS_CONTROL |-> prdata[31:7] == 25'h0; endproperty
    property p_lim; rd && paddr == PMT8_OFS_LIMIT |-> prdata[31:8] == 24'h0; endproperty
    // Hardware alone never lowers the interrupt: a write two edges back must
    property p_hold; $fell(irq) |-> $past(acc && pwrite, 2); endproperty
    a_ans: assert property (p_ans) else $error("no answer one cycle after access");
    a_one: assert property (p_one) else $error("ready longer than one cycle");
    a_err: assert property (p_err) else $error("error without ready or data");
    a_idle: assert property (p_idle) else $error("read data outside ready");
    a_cnt: assert property (p_cnt) else $error("counter wider than byte");
    a_ctl: assert property (p_ctl) else $error("control upper bits set");
    a_lim: assert property (p_lim) else $error("limit wider than byte");
    a_hold: assert property (p_hold) else $error("irq dropped without write");
    c_irq: cover property ($rose(irq));
    c_err: cover property (pslverr);
    c_rd: cover property (rd);
endmodule // pmt8_chk
bind pmt8_timer pmt8_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq));

// File: tb/period_match_timer8_tb_top.sv
// Testbench for pmt8_timer: APB master, rate and flag checks against a model.
// Assumes one 125 MHz clock and the register map of pmt8_pkg.
`timescale 1ns/1ps
module period_match_timer8_tb_top
    import pmt8_pkg::*;
;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, er;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, v, seed = 32'h66c5;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] mdl[5] = '{32'h0, 32'hff, 32'h0, 32'h0, 32'h0};
    int          n_mismatch = 0, n_checks = 0, cyc = 0, r, p;
    pmt8_timer uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    initial forever #4 clk = ~clk;
    // Whole run is well under 20000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Tick phase is free-running, so counts are known only to one step
    task automatic chk_rng(string nm, int lo, int hi, logic [31:0] g);
        n_checks++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0d..%0d seen %h", nm, lo, hi, g);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            end_of_test();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d checks %0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1;
        for (r = 0; r < 5; r++) begin
            apb(0, 8'(r * 4), 0);
            chk("reset value", mdl[r], rd);
        end
        apb(0, 8'h14, 0);
        chk("unmapped error", 1, {31'h0, er});
        repeat (4) begin
            v = xs();
            apb(1, PMT8_OFS_COUNTER, v);
            apb(1, PMT8_OFS_LIMIT, v >> 8);
            apb(0, PMT8_OFS_COUNTER, 0);
            chk("counter", v & 32'hff, rd);
            apb(0, PMT8_OFS_LIMIT, 0);
            chk("limit", (v >> 8) & 32'hff, rd);
        end
        apb(1, PMT8_OFS_COUNTER, 32'h37);
        apb(1, PMT8_OFS_CONTROL, 32'h7b);
        repeat (100) @(posedge clk);
        apb(0, PMT8_OFS_COUNTER, 0);
        chk("held counter", 32'h37, rd);
        apb(0, PMT8_OFS_CONTROL, 0);
        chk("control", 32'h7b, rd);
        for (r = 0; r < 4; r++) begin
            p = (r == 0) ? 1 : (r == 1) ? 4 : 16;
            apb(1, PMT8_OFS_LIMIT, 32'hff);
            apb(1, PMT8_OFS_COUNTER, 0);
            apb(1, PMT8_OFS_CONTROL, 4 | r);
            repeat (80 * p - 3) @(posedge clk);
            apb(1, PMT8_OFS_CONTROL, r);
            apb(0, PMT8_OFS_COUNTER, 0);
            chk_rng("prescaled count", 19, 21, rd);
        end
        apb(1, PMT8_OFS_LIMIT, 3);
        apb(1, PMT8_OFS_MASK, 1);
        for (r = 0; r < 16; r++) begin
            apb(1, PMT8_OFS_COUNTER, 0);
            apb(1, PMT8_OFS_CONTROL, (r << 3) | 4);
            repeat (16 * (r + 1) - 12) @(posedge clk);
            apb(0, PMT8_OFS_STATUS, 0);
            chk("flag early", 0, rd);
            repeat (16) @(posedge clk);
            apb(0, PMT8_OFS_STATUS, 0);
            chk("flag set", 1, rd);
            apb(1, PMT8_OFS_CONTROL, 0);
            apb(0, PMT8_OFS_COUNTER, 0);
            chk_rng("wrapped counter", 0, 3, rd);
            chk("irq high", 1, {31'h0, irq});
            apb(1, PMT8_OFS_STATUS, 1);
            @(posedge clk);
            chk("irq cleared", 0, {31'h0, irq});
        end
        // Strobe bit 0 low must leave the limit untouched
        pstrb <= 4'he;
        apb(1, PMT8_OFS_LIMIT, 32'h12);
        pstrb <= 4'hf;
        apb(0, PMT8_OFS_LIMIT, 0);
        chk("limit after masked strobe", 32'h3, rd);
        // Masked flag sets status but keeps irq low
        apb(1, PMT8_OFS_MASK, 0);
        apb(1, PMT8_OFS_CONTROL, 4);
        repeat (40) @(posedge clk);
        apb(1, PMT8_OFS_CONTROL, 0);
        apb(0, PMT8_OFS_STATUS, 0);
        chk("masked flag", 1, rd);
        chk("masked irq", 0, {31'h0, irq});
        apb(1, PMT8_OFS_STATUS, 1);
        apb(0, PMT8_OFS_STATUS, 0);
        chk("flag cleared", 0, rd);
        apb(1, PMT8_OFS_COUNTER, 32'h55);
        apb(1, PMT8_OFS_CONTROL, 4);
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        apb(0, PMT8_OFS_COUNTER, 0);
        chk("counter after reset", 0, rd);
        apb(0, PMT8_OFS_LIMIT, 0);
        chk("limit after reset", 32'hff, rd);
        end_of_test();
    end
endmodule // period_match_timer8_tb_top
